// *** design/viu_pkg.sv ***
// Package for the vectored interrupt unit: source indices, vectors, reset values.
// Assumes an 8-bit core with a 13-bit program counter on the same clock.
package viu_pkg;
  localparam int          NUM_SRC      = 8;
  localparam logic [7:0]  FLAG_RST     = 8'h00;
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [12:0] VEC_BASE     = 13'h0003;
  localparam logic [12:0] VEC_STEP     = 13'h0003;
  localparam logic [12:0] VEC_LAST     = 13'h0018;
  // Source bit positions in flag and mask registers
  localparam int          SRC_TMR      = 0;
  localparam int          SRC_EXT0     = 1;
  localparam int          SRC_EXT1     = 2;
  localparam int          SRC_CNT1     = 3;
  localparam int          SRC_CNT2     = 4;
  localparam int          SRC_HPW      = 5;
  localparam int          SRC_LPW      = 6;
  localparam int          SRC_PCHG     = 7;
  // Sources detected on a falling edge of an internal level
  localparam logic [7:0]  FALL_SRC     = 8'h79;

  typedef struct packed {
    logic [7:0] working_register;
    logic [7:0] processor_status;
  } viu_ctx_t;

  typedef enum logic [1:0] {
    VIU_IDLE,
    VIU_ENTER,
    VIU_SERVICE
  } viu_state_t;
endpackage : viu_pkg

// *** design/viu_vectored_interrupt_unit.sv ***
// Vectored interrupt unit: flags, mask, global enable, vector, context backup.
// Assumes core strobes arrive synchronous to i_clk_sys; external pins are raw.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Accept exactly eight interrupt request sources
// - Timer and counters trigger on falling edge
// - Enabled falling edge sets its flag bit
// - Separate per-source flag and mask registers
// - Enable/disable instructions gate request acceptance
// - Taken request redirects fetch to vector
// - Vectors three apart, 0003H through 0018H
// - Save working and status before service
// - Restore working and status at return
// - No nesting of service routines
// - Requests during service stay pending
// - Mask bit order matches source order
// - Masked port change wakes without vectoring
module viu_vectored_interrupt_unit (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  input  wire logic [7:0]       i_int_src_level,
  input  wire logic             i_ext_irq_zero,
  input  wire logic             i_ext_irq_one,
  input  wire logic             i_port_change,
  input  wire logic             i_global_irq_on_instr,
  input  wire logic             i_global_irq_off_instr,
  input  wire logic             i_flag_wr,
  input  wire logic [7:0]       i_flag_wdata,
  input  wire logic             i_mask_wr,
  input  wire logic [7:0]       i_mask_wdata,
  input  wire logic             i_fetch_ack,
  input  wire logic             i_reti,
  input  wire viu_pkg::viu_ctx_t i_ctx,
  input  wire logic             i_sleeping,
  output logic                  o_irq_req,
  output logic [12:0]           o_vector,
  output logic                  o_ctx_save,
  output viu_pkg::viu_ctx_t     o_ctx_backup,
  output logic                  o_ctx_restore,
  output logic                  o_wake,
  output logic                  o_in_service,
  output logic                  o_global_en,
  output logic [7:0]            o_interrupt_flag_register,
  output logic [7:0]            o_interrupt_mask_register
);
  logic [7:0]          interrupt_flag_register_r;
  logic [7:0]          interrupt_mask_register_r;
  logic                global_en_r;
  logic [7:0]          lvl_prev_r;
  logic [2:0]          pin_s1_r;
  logic [2:0]          pin_s2_r;
  logic [2:0]          pin_prev_r;
  logic [7:0]          cur_lvl;
  logic [7:0]          prev_lvl;
  logic [7:0]          fall;
  logic [7:0]          pend;
  logic [2:0]          sel_idx;
  logic [12:0]         vector_nxt;
  viu_pkg::viu_state_t state_r;
  viu_pkg::viu_ctx_t   backup_r;
  logic [12:0]         vector_r;
  logic                wake_r;

  // External pins and port change pass two flops before any edge logic
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      pin_s1_r   <= 3'h7;
      pin_s2_r   <= 3'h7;
      pin_prev_r <= 3'h7;
    end
    else
    begin
      pin_s1_r   <= {~i_port_change, i_ext_irq_one, i_ext_irq_zero};
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      lvl_prev_r <= 8'h00;
    else
      lvl_prev_r <= i_int_src_level;
  end

  // Internal sources use the core level; pins use the synchronised copy
  always_comb
  begin
    cur_lvl  = i_int_src_level;
    prev_lvl = lvl_prev_r;
    cur_lvl[viu_pkg::SRC_EXT0]  = pin_s2_r[0];
    cur_lvl[viu_pkg::SRC_EXT1]  = pin_s2_r[1];
    cur_lvl[viu_pkg::SRC_PCHG]  = pin_s2_r[2];
    prev_lvl[viu_pkg::SRC_EXT0] = pin_prev_r[0];
    prev_lvl[viu_pkg::SRC_EXT1] = pin_prev_r[1];
    prev_lvl[viu_pkg::SRC_PCHG] = pin_prev_r[2];
  end

  // One falling-edge detector per source
  genvar g;
  generate
    for (g = 0; g < viu_pkg::NUM_SRC; g++)
    begin : g_src
      assign fall[g] = prev_lvl[g] & ~cur_lvl[g];
    end
  endgenerate

  // Flags record edges even while masked; a set beats a same-cycle clear
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      interrupt_flag_register_r <= viu_pkg::FLAG_RST;
    else if (i_flag_wr)
      interrupt_flag_register_r <= (interrupt_flag_register_r & i_flag_wdata) | fall;
    else
      interrupt_flag_register_r <= interrupt_flag_register_r | fall;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      interrupt_mask_register_r <= viu_pkg::MASK_RST;
    else if (i_mask_wr)
      interrupt_mask_register_r <= i_mask_wdata;
  end

  // Enable changes only on instruction strobes; off wins when both arrive together
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      global_en_r <= 1'b0;
    else if (i_global_irq_off_instr)
      global_en_r <= 1'b0;
    else if (i_global_irq_on_instr)
      global_en_r <= 1'b1;
  end

  assign pend = interrupt_flag_register_r & interrupt_mask_register_r;

  // Lowest index wins, which is also the lowest vector
  always_comb
  begin
    sel_idx = 3'h0;
    for (int k = viu_pkg::NUM_SRC - 1; k >= 0; k--)
    begin
      if (pend[k])
        sel_idx = 3'(k);
    end
    vector_nxt = viu_pkg::VEC_BASE + 13'(sel_idx) * viu_pkg::VEC_STEP;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_r  <= viu_pkg::VIU_IDLE;
      vector_r <= viu_pkg::VEC_BASE;
    end
    else
    begin
      case (state_r)
        viu_pkg::VIU_IDLE:
        begin
          if (global_en_r && (|pend))
          begin
            state_r  <= viu_pkg::VIU_ENTER;
            vector_r <= vector_nxt;
          end
        end
        viu_pkg::VIU_ENTER:
        begin
          if (i_fetch_ack)
            state_r <= viu_pkg::VIU_SERVICE;
        end
        viu_pkg::VIU_SERVICE:
        begin
          if (i_reti)
            state_r <= viu_pkg::VIU_IDLE;
        end
        default:
          state_r <= viu_pkg::VIU_IDLE;
      endcase
    end
  end

  // Context is captured when the core accepts the vector, before the first routine instruction
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      backup_r <= '0;
    else if (state_r == viu_pkg::VIU_ENTER && i_fetch_ack)
      backup_r <= i_ctx;
  end

  // Masked port change only wakes; the core then continues in line
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      wake_r <= 1'b0;
    else
      wake_r <= i_sleeping && (|fall);
  end

  assign o_irq_req     = (state_r == viu_pkg::VIU_ENTER);
  assign o_vector      = vector_r;
  assign o_ctx_save    = (state_r == viu_pkg::VIU_ENTER) && i_fetch_ack;
  assign o_ctx_backup  = backup_r;
  assign o_ctx_restore = (state_r == viu_pkg::VIU_SERVICE) && i_reti;
  assign o_wake        = wake_r;
  assign o_in_service  = (state_r != viu_pkg::VIU_IDLE);
  assign o_global_en   = global_en_r;
  assign o_interrupt_flag_register = interrupt_flag_register_r;
  assign o_interrupt_mask_register = interrupt_mask_register_r;

  // Assertions
  sequence s_taken;
    state_r == viu_pkg::VIU_IDLE && global_en_r && (|pend);
  endsequence

  property p_vector_range;
    @(posedge i_clk_sys) disable iff (i_reset)
      o_irq_req |-> (o_vector >= viu_pkg::VEC_BASE && o_vector <= viu_pkg::VEC_LAST);
  endproperty
  a_vector_range: assert property (p_vector_range) else $error("vector out of range");

  property p_vector_pick;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_taken |=> ($past(pend) & ~($past(pend) - 8'h01)) ==
                  (8'h01 << ((o_vector - viu_pkg::VEC_BASE) / viu_pkg::VEC_STEP));
  endproperty
  a_vector_pick: assert property (p_vector_pick) else $error("vector does not match source");

  property p_no_take_disabled;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_r == viu_pkg::VIU_IDLE && !global_en_r) |=> !o_irq_req;
  endproperty
  a_no_take_disabled: assert property (p_no_take_disabled) else $error("request taken while disabled");

  property p_flag_set;
    @(posedge i_clk_sys) disable iff (i_reset)
      (|fall) |=> ((interrupt_flag_register_r & $past(fall)) == $past(fall));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge did not set flag");

  property p_no_nest;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_r == viu_pkg::VIU_SERVICE && !i_reti) |=> state_r == viu_pkg::VIU_SERVICE;
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("service routine nested");

  property p_save;
    @(posedge i_clk_sys) disable iff (i_reset)
      o_ctx_save |=> o_ctx_backup == $past(i_ctx);
  endproperty
  a_save: assert property (p_save) else $error("context not saved");

  property p_restore;
    @(posedge i_clk_sys) disable iff (i_reset)
      o_ctx_restore |-> ##1 state_r == viu_pkg::VIU_IDLE;
  endproperty
  a_restore: assert property (p_restore) else $error("restore did not end service");

  property p_mask_gate;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_r == viu_pkg::VIU_IDLE && pend == 8'h00) |=> !o_irq_req;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("request without masked flag");

endmodule : viu_vectored_interrupt_unit
`default_nettype wire

// *** bench/viu_core_model.sv ***
// Core fetch model: accepts the vector request after a chosen delay.
// Assumes the request is a level that stands until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module viu_core_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_irq_req,
  input  wire logic [3:0] i_ack_delay,
  output logic            o_fetch_ack
);
  logic [3:0] wait_r;
  // Slow answers keep the request standing for several cycles
  assign o_fetch_ack = i_irq_req && (wait_r == i_ack_delay);
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || !i_irq_req || o_fetch_ack)
      wait_r <= 4'h0;
    else
      wait_r <= wait_r + 4'h1;
  end
endmodule : viu_core_model
`default_nettype wire

// *** bench/viu_vectored_interrupt_unit_tb_top.sv ***
// Testbench for the vectored interrupt unit with a core fetch model.
// Assumes the unit's registers are plain ports and one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module viu_vectored_interrupt_unit_tb_top;
  logic              i_clk_sys = 1'b0;
  logic              i_reset   = 1'b1;
  logic [7:0]        lvl       = 8'hFF;
  logic              ext0      = 1'b1;
  logic              ext1      = 1'b1;
  logic              pchg      = 1'b0;
  logic              on        = 1'b0;
  logic              off       = 1'b0;
  logic              flag_wr   = 1'b0;
  logic              mask_wr   = 1'b0;
  logic              reti      = 1'b0;
  logic              sleeping  = 1'b0;
  logic [7:0]        flag_wd   = 8'hFF;
  logic [7:0]        mask_wd   = 8'h00;
  logic [3:0]        ack_dly   = 4'h0;
  viu_pkg::viu_ctx_t ctx       = 16'hA55A;
  logic              ack, irq, csave, crest, wake, insvc, gen;
  logic [12:0]       vec;
  viu_pkg::viu_ctx_t backup;
  logic [7:0]        flags, mask;
  int                n_mismatch = 0;
  int                compares   = 0;
  int                n_wake     = 0;
  int                n_irq      = 0;
  localparam int     TIMEOUT_CYCLES = 3000;

  always #20 i_clk_sys = ~i_clk_sys;

  viu_vectored_interrupt_unit dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_int_src_level(lvl),
    .i_ext_irq_zero(ext0), .i_ext_irq_one(ext1), .i_port_change(pchg), .i_global_irq_on_instr(on),
    .i_global_irq_off_instr(off), .i_flag_wr(flag_wr), .i_flag_wdata(flag_wd), .i_mask_wr(mask_wr),
    .i_mask_wdata(mask_wd), .i_fetch_ack(ack), .i_reti(reti), .i_ctx(ctx), .i_sleeping(sleeping),
    .o_irq_req(irq), .o_vector(vec), .o_ctx_save(csave), .o_ctx_backup(backup), .o_ctx_restore(crest),
    .o_wake(wake), .o_in_service(insvc), .o_global_en(gen), .o_interrupt_flag_register(flags),
    .o_interrupt_mask_register(mask));

  viu_core_model core (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_irq_req(irq), .i_ack_delay(ack_dly),
    .o_fetch_ack(ack));

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Wake is a one-cycle pulse, so pulses are counted here rather than polled
  always @(posedge i_clk_sys)
  begin
    if (wake === 1'b1)
      n_wake <= n_wake + 1;
    if (irq === 1'b1)
      n_irq <= n_irq + 1;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Waits up to 30 cycles for the request (sel 0) or the context save strobe (sel 1)
  task automatic await(input int sel);
    for (int k = 0; k < 30 && ((sel == 0) ? irq : csave) !== 1'b1; k++)
      @(posedge i_clk_sys) #1;
  endtask : await

  task automatic fire(input int i);
    @(posedge i_clk_sys);
    if (i == 1) ext0 <= 1'b0;
    else if (i == 2) ext1 <= 1'b0;
    else if (i == 7) pchg <= 1'b1;
    else lvl[i] <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    ext0 <= 1'b1;
    ext1 <= 1'b1;
    pchg <= 1'b0;
    lvl  <= 8'hFF;
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask : fire

  task automatic gpulse(input logic en);
    @(posedge i_clk_sys);
    if (en) on <= 1'b1; else off <= 1'b1;
    @(posedge i_clk_sys);
    on  <= 1'b0;
    off <= 1'b0;
  endtask : gpulse

  task automatic enter(input logic [12:0] v);
    await(0);
    chk(vec, v);
    await(1);
    @(posedge i_clk_sys);
    ctx <= 16'h0F0F;
    #1 chk({insvc, irq, backup}, {2'b10, 16'hA55A});
  endtask : enter

  task automatic leave(input int b);
    @(posedge i_clk_sys);
    flag_wd <= ~(8'h01 << b);
    flag_wr <= 1'b1;
    @(posedge i_clk_sys);
    flag_wr <= 1'b0;
    reti    <= 1'b1;
    #1 chk(crest, 1'b1);
    @(posedge i_clk_sys);
    reti <= 1'b0;
    ctx  <= 16'hA55A;
    #1 chk({crest, insvc}, 2'b00);
  endtask : leave

  task automatic t_vectors;
    @(posedge i_clk_sys);
    mask_wd <= 8'hFF;
    mask_wr <= 1'b1;
    @(posedge i_clk_sys);
    mask_wr <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      ack_dly <= 4'(i);
      fire(i);
      chk({irq, flags}, {1'b0, 8'h01 << i});
      gpulse(1'b1);
      enter(13'(3 + 3 * i));
      leave(i);
      gpulse(1'b0);
    end
    chk(24'(n_wake), 24'h000000);
    $display("vector table test done");
  endtask : t_vectors

  task automatic t_nesting;
    int irq0;
    fire(6);
    fire(3);
    chk(flags, 8'h48);
    gpulse(1'b1);
    enter(13'h000C);
    irq0 = n_irq;
    fire(0);
    chk({n_irq != irq0, flags}, {1'b0, 8'h49});
    leave(3);
    enter(13'h0003);
    leave(0);
    enter(13'h0015);
    leave(6);
    $display("nesting and priority test done");
  endtask : t_nesting

  task automatic t_masked;
    int irq0;
    int wake0;
    @(posedge i_clk_sys);
    mask_wd  <= 8'h7E;
    mask_wr  <= 1'b1;
    sleeping <= 1'b1;
    @(posedge i_clk_sys);
    mask_wr <= 1'b0;
    irq0 = n_irq;
    fire(0);
    wake0 = n_wake;
    fire(7);
    chk({n_wake != wake0, n_irq != irq0, mask, flags}, {2'b10, 16'h7E81});
    @(posedge i_clk_sys);
    on  <= 1'b1;
    off <= 1'b1;
    @(posedge i_clk_sys);
    on  <= 1'b0;
    off <= 1'b0;
    #1 chk(gen, 1'b0);
    $display("mask and wake test done");
  endtask : t_masked

  // The watchdog branch only counts a mismatch; the verdict is given in one place
  initial
  begin
    fork
      begin
        repeat (12) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        @(posedge i_clk_sys) #1;
        chk({flags, mask, irq, csave, crest, wake, insvc, gen}, 22'h000000);
        chk(vec, 13'h0003);
        $display("reset test done");
        t_vectors();
        t_nesting();
        t_masked();
      end
      begin
        repeat (TIMEOUT_CYCLES) @(posedge i_clk_sys);
        n_mismatch++;
        $display("timeout after %0d cycles", TIMEOUT_CYCLES);
      end
    join_any
    complete_run();
  end
endmodule : viu_vectored_interrupt_unit_tb_top
`default_nettype wire
